// [hw/pcmc_mixer.sv]
// conference mixer in the pcm transmit path with its register port
// assumes slot samples arrive synchronous to core_clk_i, at most one per cycle
`timescale 1ns/1ps
module pcmc_mixer #(
    parameter int FRAME_CYCLES = pcmc_pkg::FRAME_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic frame_sync_i,
    input wire pcmc_pkg::pcmc_slot_type tx_in_i,
    output pcmc_pkg::pcmc_slot_type tx_out_o,
    output logic mem_access_o
);
    localparam int SEL_ENTRIES = 2 * pcmc_pkg::NUM_SLOTS;

    // register file state
    logic enable_r, enable_nxt;
    logic ulaw_r, ulaw_nxt;
    logic [7:0] slot_sel_r, slot_sel_nxt;
    logic [7:0] ovf_r, ovf_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    pcmc_pkg::pcmc_param_type cfg_r [SEL_ENTRIES];
    pcmc_pkg::pcmc_param_type cfg_nxt [SEL_ENTRIES];

    // mixing state
    logic [12:0] frame_cnt_r, frame_cnt_nxt;
    logic bank_r, bank_nxt;
    logic signed [15:0] acc_r [2][pcmc_pkg::NUM_CONF];
    logic signed [15:0] acc_nxt [2][pcmc_pkg::NUM_CONF];
    logic [pcmc_pkg::NUM_SLOTS-1:0] cvalid_r [2];
    logic [pcmc_pkg::NUM_SLOTS-1:0] cvalid_nxt [2];
    logic signed [15:0] contrib_mem [2][pcmc_pkg::NUM_SLOTS];
    logic [2:0] ctag_mem [2][pcmc_pkg::NUM_SLOTS];
    pcmc_pkg::pcmc_slot_type tx_out_r, tx_out_nxt;
    logic mem_access_r, mem_access_nxt;

    // per-sample working signals
    pcmc_pkg::pcmc_param_type cur_cfg;
    logic [2:0] cur_conf;
    logic active;
    logic frame_tick;
    logic ovf_read;
    logic signed [15:0] lin;
    logic signed [16:0] sum_wide;
    logic signed [16:0] diff_wide;
    logic signed [15:0] sum_sat;
    logic signed [15:0] diff_sat;
    logic signed [15:0] own;
    logic sum_ovf;
    logic diff_ovf;
    logic sat_any;
    logic acc_bank_zero;

    function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
        // clamp both ways
        if (v > 17'(pcmc_pkg::SAT_MAX)) begin
            return pcmc_pkg::SAT_MAX;
        end else if (v < 17'(pcmc_pkg::SAT_MIN)) begin
            return pcmc_pkg::SAT_MIN;
        end
        return v[15:0];
    endfunction

    function automatic logic [7:0] compress(input logic signed [15:0] x, input logic ulaw);
        logic sign;
        logic [15:0] mag;
        logic [12:0] m;
        logic [2:0] seg;
        logic [3:0] mant;
        sign = x[15];
        mag = sign ? 16'(-x) : 16'(x);
        seg = 3'h0;
        if (ulaw) begin
            if (mag > pcmc_pkg::ULAW_CLIP || sign && mag == 16'h8000) begin
                mag = pcmc_pkg::ULAW_CLIP;
            end
            mag = mag + pcmc_pkg::ULAW_BIAS;
            for (int i = 0; i < 8; i++) begin
                if (mag[i+7]) begin
                    seg = 3'(i);
                end
            end
            // four-bit shift sum, a three-bit one wraps for the top segments
            mant = 4'(mag >> (4'(seg) + 4'h3));
            return ~{sign, seg, mant};
        end
        m = mag[15:3];
        if (m > pcmc_pkg::ALAW_CLIP) begin
            m = pcmc_pkg::ALAW_CLIP;
        end
        if (m < pcmc_pkg::ALAW_SEG0_LIM) begin
            mant = m[4:1];
        end else begin
            for (int i = 5; i < 12; i++) begin
                if (m[i]) begin
                    seg = 3'(i - 4);
                end
            end
            mant = 4'(m >> seg);
        end
        return {~sign, seg, mant} ^ pcmc_pkg::ALAW_XOR;
    endfunction

    pcmc_sample_cond u_cond (
        .code_i(tx_in_i.data),
        .ulaw_i(ulaw_r),
        .noise_i(cur_cfg.noise),
        .att_i(cur_cfg.att),
        .lin_o(lin)
    );

    // register port
    always_comb begin
        enable_nxt = enable_r;
        ulaw_nxt = ulaw_r;
        slot_sel_nxt = slot_sel_r;
        cfg_nxt = cfg_r;
        rdata_nxt = 8'h00;
        ovf_read = reg_rd_i && reg_addr_i == pcmc_pkg::ADDR_OVF_FLAGS;
        if (reg_wr_i) begin
            case (reg_addr_i)
                pcmc_pkg::ADDR_SLOT_SEL: slot_sel_nxt = reg_wdata_i;
                pcmc_pkg::ADDR_GLOBAL_CTL: begin
                    enable_nxt = reg_wdata_i[pcmc_pkg::GCTL_ENABLE_BIT];
                    ulaw_nxt = reg_wdata_i[pcmc_pkg::GCTL_LAW_BIT];
                end
                // one parameter entry per slot and direction
                pcmc_pkg::ADDR_SLOT_PARAM: cfg_nxt[slot_sel_r] = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                pcmc_pkg::ADDR_OVF_FLAGS: rdata_nxt = ovf_r;
                pcmc_pkg::ADDR_SLOT_SEL: rdata_nxt = slot_sel_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_r <= 1'b0;
            ulaw_r <= 1'b0;
            slot_sel_r <= pcmc_pkg::RESET_BYTE;
            rdata_r <= pcmc_pkg::RESET_BYTE;
            for (int i = 0; i < SEL_ENTRIES; i++) begin
                cfg_r[i] <= pcmc_pkg::RESET_BYTE;
            end
        end else begin
            enable_r <= enable_nxt;
            ulaw_r <= ulaw_nxt;
            slot_sel_r <= slot_sel_nxt;
            rdata_r <= rdata_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // mixing datapath
    always_comb begin
        frame_tick = frame_sync_i || frame_cnt_r == 13'(FRAME_CYCLES - 1);
        frame_cnt_nxt = frame_tick ? 13'h0000 : frame_cnt_r + 13'h0001;
        bank_nxt = frame_tick ? !bank_r : bank_r;
        // only transmit-direction entries take part
        cur_cfg = cfg_r[{tx_in_i.slot, pcmc_pkg::DIR_TX}];
        cur_conf = cur_cfg.conf;
        active = tx_in_i.valid && enable_r && cur_cfg.member;
        // accumulate into the filling bank
        sum_wide = 17'(acc_r[bank_r][cur_conf]) + 17'(lin);
        sum_sat = sat16(sum_wide);
        sum_ovf = sum_wide != 17'(sum_sat);
        // own contribution only if it was summed into the same conference
        if (cvalid_r[!bank_r][tx_in_i.slot] && ctag_mem[!bank_r][tx_in_i.slot] == cur_conf) begin
            own = contrib_mem[!bank_r][tx_in_i.slot];
        end else begin
            own = 16'sh0000;
        end
        diff_wide = 17'(acc_r[!bank_r][cur_conf]) - 17'(own);
        diff_sat = sat16(diff_wide);
        diff_ovf = diff_wide != 17'(diff_sat);
        sat_any = active && (sum_ovf || diff_ovf);
        acc_nxt = acc_r;
        cvalid_nxt = cvalid_r;
        if (active) begin
            acc_nxt[bank_r][cur_conf] = sum_sat;
            cvalid_nxt[bank_r][tx_in_i.slot] = 1'b1;
        end
        if (frame_tick) begin
            for (int i = 0; i < pcmc_pkg::NUM_CONF; i++) begin
                acc_nxt[!bank_r][i] = 16'sh0000;
            end
            cvalid_nxt[!bank_r] = '0;
        end
        // set wins over the read clear
        ovf_nxt = ovf_read ? pcmc_pkg::OVF_RESET : ovf_r;
        if (sat_any) begin
            ovf_nxt[cur_conf] = 1'b1;
        end
        tx_out_nxt.valid = tx_in_i.valid;
        tx_out_nxt.slot = tx_in_i.slot;
        tx_out_nxt.data = active ? compress(diff_sat, ulaw_r) : tx_in_i.data;
        mem_access_nxt = active;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_cnt_r <= 13'h0000;
            bank_r <= 1'b0;
            ovf_r <= pcmc_pkg::OVF_RESET;
            tx_out_r <= '0;
            mem_access_r <= 1'b0;
            for (int b = 0; b < 2; b++) begin
                cvalid_r[b] <= '0;
                for (int i = 0; i < pcmc_pkg::NUM_CONF; i++) begin
                    acc_r[b][i] <= 16'sh0000;
                end
            end
        end else begin
            frame_cnt_r <= frame_cnt_nxt;
            bank_r <= bank_nxt;
            ovf_r <= ovf_nxt;
            tx_out_r <= tx_out_nxt;
            mem_access_r <= mem_access_nxt;
            cvalid_r <= cvalid_nxt;
            acc_r <= acc_nxt;
        end
    end

    // contribution store, guarded by cvalid_r so no reset is needed
    always_ff @(posedge core_clk_i) begin
        if (active) begin
            contrib_mem[bank_r][tx_in_i.slot] <= lin;
            ctag_mem[bank_r][tx_in_i.slot] <= cur_conf;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign tx_out_o = tx_out_r;
    assign mem_access_o = mem_access_r;

    always_comb begin
        acc_bank_zero = 1'b1;
        for (int i = 0; i < pcmc_pkg::NUM_CONF; i++) begin
            if (acc_r[bank_r][i] != 16'sh0000) begin
                acc_bank_zero = 1'b0;
            end
        end
    end

    property p_bank_swap;
        @(posedge core_clk_i) disable iff (rst_i)
        frame_tick |=> bank_r != $past(bank_r);
    endproperty
    a_bank_swap: assert property (p_bank_swap) else $error("sum banks did not swap at frame");

    property p_acc_clear;
        @(posedge core_clk_i) disable iff (rst_i)
        frame_tick |=> acc_bank_zero;
    endproperty
    a_acc_clear: assert property (p_acc_clear) else $error("new frame sums not cleared");

    property p_pass_disabled;
        @(posedge core_clk_i) disable iff (rst_i)
        tx_in_i.valid && !enable_r |=> tx_out_o.valid && tx_out_o.data == $past(tx_in_i.data);
    endproperty
    a_pass_disabled: assert property (p_pass_disabled) else $error("disabled mixer altered slot data");

    property p_slot_latency;
        @(posedge core_clk_i) disable iff (rst_i)
        tx_in_i.valid |=> tx_out_o.valid && tx_out_o.slot == $past(tx_in_i.slot);
    endproperty
    a_slot_latency: assert property (p_slot_latency) else $error("slot output not one cycle after input");

    property p_ovf_set;
        @(posedge core_clk_i) disable iff (rst_i)
        sat_any |=> ovf_r[$past(cur_conf)];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("saturation did not flag its conference");

    property p_ovf_sticky;
        @(posedge core_clk_i) disable iff (rst_i)
        !ovf_read |=> (ovf_r & $past(ovf_r)) == $past(ovf_r);
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost without a read");

    property p_ovf_read;
        @(posedge core_clk_i) disable iff (rst_i)
        ovf_read |=> reg_rdata_o == $past(ovf_r);
    endproperty
    a_ovf_read: assert property (p_ovf_read) else $error("overflow read returned wrong flags");

    property p_ovf_clear;
        @(posedge core_clk_i) disable iff (rst_i)
        ovf_read && !sat_any |=> ovf_r == 8'h00;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow read did not clear flags");

    property p_mem_access;
        @(posedge core_clk_i) disable iff (rst_i)
        mem_access_o |-> $past(enable_r) && $past(tx_in_i.valid);
    endproperty
    a_mem_access: assert property (p_mem_access) else $error("memory access while mixer disabled");
endmodule

// [hw/pcmc_pkg.sv]
// constants, field layouts and carrier types of the pcm conference mixer
// assumes a 40 MHz core clock and one transmit slot sample presented per cycle at most
package pcmc_pkg;

    localparam int NUM_CONF = 8;
    localparam int NUM_SLOTS = 128;
    localparam int SLOT_W = 7;
    localparam int CONF_W = 3;

    // register offsets
    localparam logic [7:0] ADDR_SLOT_SEL = 8'h10;
    localparam logic [7:0] ADDR_OVF_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_GLOBAL_CTL = 8'h18;
    localparam logic [7:0] ADDR_SLOT_PARAM = 8'hD1;

    // field positions and reset values
    localparam int GCTL_ENABLE_BIT = 0;
    localparam int GCTL_LAW_BIT = 7;
    localparam int SLOT_SEL_DIR_BIT = 0;
    localparam logic DIR_TX = 1'b0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] OVF_RESET = 8'h00;

    // timing
    localparam int FRAME_NS = 125000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;

    // arithmetic
    localparam logic signed [15:0] SAT_MAX = 16'sh7FFF;
    localparam logic signed [15:0] SAT_MIN = 16'sh8000;
    localparam logic [15:0] NOISE_THR1 = 16'h0005;
    localparam logic [15:0] NOISE_THR2 = 16'h0009;
    localparam logic [15:0] NOISE_THR3 = 16'h0010;
    localparam logic [8:0] ATT_MUL_3DB = 9'h0B5;
    localparam logic [8:0] ATT_MUL_9DB = 9'h05B;

    // companding
    localparam logic [7:0] ALAW_XOR = 8'h55;
    localparam logic [15:0] ALAW_ROUND = 16'h0008;
    localparam logic [15:0] ALAW_SEG_BIAS = 16'h0100;
    localparam logic [15:0] ULAW_BIAS = 16'h0084;
    localparam logic [15:0] ULAW_CLIP = 16'h7F7B;
    localparam logic [12:0] ALAW_CLIP = 13'h0FFF;
    localparam logic [12:0] ALAW_SEG0_LIM = 13'h0020;

    typedef struct packed {
        logic member;
        logic [1:0] att;
        logic [1:0] noise;
        logic [2:0] conf;
    } pcmc_param_type;

    typedef struct packed {
        logic valid;
        logic [6:0] slot;
        logic [7:0] data;
    } pcmc_slot_type;

endpackage

// [hw/pcmc_sample_cond.sv]
// input conditioning of one member sample: expansion, noise gate, attenuation
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
module pcmc_sample_cond (
    input wire logic [7:0] code_i,
    input wire logic ulaw_i,
    input wire logic [1:0] noise_i,
    input wire logic [1:0] att_i,
    output logic signed [15:0] lin_o
);
    logic [7:0] a_code;
    logic [7:0] u_code;
    logic [15:0] t;
    logic [15:0] mag;
    logic [15:0] thr;
    logic neg;
    logic signed [15:0] lin;
    logic [8:0] mul;
    logic signed [25:0] prod;

    always_comb begin
        a_code = code_i ^ pcmc_pkg::ALAW_XOR;
        u_code = ~code_i;
        // law select between the two expansions
        if (ulaw_i) begin
            t = (16'({u_code[3:0], 3'b000}) + pcmc_pkg::ULAW_BIAS) << u_code[6:4];
            mag = t - pcmc_pkg::ULAW_BIAS;
            neg = u_code[7];
        end else begin
            t = 16'({a_code[3:0], 4'b0000}) + pcmc_pkg::ALAW_ROUND;
            if (a_code[6:4] != 3'h0) begin
                t = (t + pcmc_pkg::ALAW_SEG_BIAS) << (a_code[6:4] - 3'h1);
            end
            mag = t;
            neg = !a_code[7];
        end
        // noise gate on magnitude
        case (noise_i)
            2'h1: thr = pcmc_pkg::NOISE_THR1;
            2'h2: thr = pcmc_pkg::NOISE_THR2;
            2'h3: thr = pcmc_pkg::NOISE_THR3;
            default: thr = 16'h0000;
        endcase
        if (noise_i != 2'h0 && mag <= thr) begin
            mag = 16'h0000;
        end
        lin = neg ? -$signed(mag) : $signed(mag);
        // attenuation, read live every sample
        case (att_i)
            2'h1: mul = pcmc_pkg::ATT_MUL_3DB;
            2'h3: mul = pcmc_pkg::ATT_MUL_9DB;
            default: mul = 9'h000;
        endcase
        prod = $signed({{10{lin[15]}}, lin}) * $signed({17'h00000, mul});
        case (att_i)
            2'h0: lin_o = lin;
            2'h2: lin_o = lin >>> 1;
            default: lin_o = prod[23:8];
        endcase
    end
endmodule

// [test/pcmc_highway_model.sv]
// behavioural pcm highway that feeds transmit slot samples and frame pulses
// assumes the testbench calls its tasks; every change lands just after a rising edge
`timescale 1ns/1ps
module pcmc_highway_model (
    input wire logic core_clk_i,
    output logic frame_sync_o,
    output pcmc_pkg::pcmc_slot_type tx_o
);
    logic busy_r = 1'b0;
    logic [14:0] pat_r = 15'h0000;
    pcmc_pkg::pcmc_slot_type cur_r = '0;

    initial frame_sync_o = 1'b0;

    // idle lines carry a moving pattern, never the last sample
    always @(posedge core_clk_i) begin
        pat_r <= pat_r + 15'h1235;
    end

    assign tx_o = busy_r ? cur_r : {1'b0, pat_r};

    // one sample, valid for exactly one cycle
    task automatic send(input logic [6:0] slot, input logic [7:0] data);
        @(posedge core_clk_i);
        busy_r <= 1'b1;
        cur_r <= {1'b1, slot, data};
        @(posedge core_clk_i);
        busy_r <= 1'b0;
    endtask

    // frame boundary, only between samples
    task automatic sync();
        @(posedge core_clk_i);
        frame_sync_o <= 1'b1;
        @(posedge core_clk_i);
        frame_sync_o <= 1'b0;
    endtask
endmodule

// [test/tb_pcmc_mixer.sv]
// self-checking testbench of the pcm conference mixer
// assumes the highway model in pcmc_highway_model.sv and mu-law/a-law 16-bit expansion
`timescale 1ns/1ps
module tb_pcmc_mixer;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic frame_sync_i;
    pcmc_pkg::pcmc_slot_type tx_in_i;
    pcmc_pkg::pcmc_slot_type tx_out_o;
    logic mem_access_o;
    int error_cnt = 0;
    int n_checks = 0;
    localparam int FRAME_LEN = 4000;

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    pcmc_highway_model hw (.core_clk_i(core_clk_i), .frame_sync_o(frame_sync_i), .tx_o(tx_in_i));

    pcmc_mixer #(.FRAME_CYCLES(FRAME_LEN)) dut (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .frame_sync_i(frame_sync_i),
        .tx_in_i(tx_in_i),
        .tx_out_o(tx_out_o),
        .mem_access_o(mem_access_o)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe, then returns to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        check("reg read", {8'h00, reg_rdata_o}, {8'h00, exp});
        @(negedge core_clk_i);
        check("read idle", {8'h00, reg_rdata_o}, 16'h0000);
    endtask

    task automatic set_slot(input logic [6:0] slot, input logic dir, input logic [7:0] prm);
        wr(pcmc_pkg::ADDR_SLOT_SEL, {slot, dir});
        wr(pcmc_pkg::ADDR_SLOT_PARAM, prm);
    endtask

    // exp or m below zero: not judged
    task automatic send(input logic [6:0] slot, input logic [7:0] data, input int exp, input int m);
        hw.send(slot, data);
        @(negedge core_clk_i);
        if (exp >= 0) check("slot out", tx_out_o, {1'b1, slot, exp[7:0]});
        if (m >= 0) check("mem access", {15'h0000, mem_access_o}, 16'(m));
    endtask

    task automatic t_regs();
        rd(pcmc_pkg::ADDR_OVF_FLAGS, pcmc_pkg::OVF_RESET);
        wr(pcmc_pkg::ADDR_SLOT_SEL, 8'h0B);
        rd(pcmc_pkg::ADDR_SLOT_SEL, 8'h0B);
        wr(pcmc_pkg::ADDR_OVF_FLAGS, 8'hFF);
        rd(pcmc_pkg::ADDR_OVF_FLAGS, 8'h00);
        rd(pcmc_pkg::ADDR_GLOBAL_CTL, 8'h00);
        rd(pcmc_pkg::ADDR_SLOT_PARAM, 8'h00);
        rd(8'h33, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_mix();
        set_slot(7'd5, pcmc_pkg::DIR_TX, 8'h82);
        send(7'd5, 8'h3C, 8'h3C, 0);
        wr(pcmc_pkg::ADDR_GLOBAL_CTL, 8'h81);
        set_slot(7'd20, pcmc_pkg::DIR_TX, 8'h82);
        send(7'd5, 8'hF0, 8'hFF, 1);
        send(7'd20, 8'hFE, 8'hFF, 1);
        hw.sync();
        send(7'd5, 8'hFF, 8'hFE, 1);
        send(7'd20, 8'hFF, 8'hF0, 1);
        hw.sync();
        $display("test mix done");
    endtask

    // attenuation codes, then noise thresholds at and around their limits
    task automatic t_level();
        logic [7:0] tp[8] = '{8'h82, 8'hA2, 8'hC2, 8'hE2, 8'h8A, 8'h92, 8'h92, 8'h9A};
        logic [7:0] td[8] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hFE, 8'hFE, 8'hFD, 8'hFD};
        logic [7:0] te[8] = '{8'hF0, 8'hF4, 8'hF7, 8'hFA, 8'hFE, 8'hFF, 8'hFD, 8'hFF};
        for (int i = 0; i <= 8; i++) begin
            if (i < 8) set_slot(7'd20, pcmc_pkg::DIR_TX, tp[i]);
            send(7'd5, 8'hFF, (i == 0) ? 8'hFF : te[i - 1], 1);
            if (i < 8) send(7'd20, td[i], 8'hFF, 1);
            hw.sync();
        end
        $display("test level done");
    endtask

    task automatic t_member();
        set_slot(7'd7, 1'b1, 8'h81);
        send(7'd7, 8'h5A, 8'h5A, 0);
        send(7'd40, 8'h66, 8'h66, 0);
        set_slot(7'd20, pcmc_pkg::DIR_TX, 8'h00);
        send(7'd20, 8'h77, 8'h77, 0);
        $display("test member done");
    endtask

    task automatic t_law();
        set_slot(7'd9, pcmc_pkg::DIR_TX, 8'h81);
        send(7'd9, 8'hA5, 8'hFF, 1);
        hw.sync();
        set_slot(7'd11, pcmc_pkg::DIR_TX, 8'h81);
        send(7'd9, 8'hA5, 8'hFF, 1);
        send(7'd11, 8'hA5, 8'hA5, 1);
        wr(pcmc_pkg::ADDR_GLOBAL_CTL, 8'h01);
        hw.sync();
        send(7'd9, 8'h2A, 8'h8C, 1);
        send(7'd11, 8'hA5, 8'h8C, 1);
        hw.sync();
        send(7'd9, 8'h2A, 8'hA5, 1);
        set_slot(7'd11, pcmc_pkg::DIR_TX, 8'h00);
        set_slot(7'd9, pcmc_pkg::DIR_TX, 8'h00);
        send(7'd9, 8'h2A, 8'h2A, -1);
        $display("test law done");
    endtask

    task automatic t_ovf();
        wr(pcmc_pkg::ADDR_GLOBAL_CTL, 8'h81);
        for (int s = 30; s < 33; s++) set_slot(7'(s), pcmc_pkg::DIR_TX, 8'h83);
        for (int s = 30; s < 33; s++) send(7'(s), 8'h80, 8'hFF, 1);
        hw.sync();
        send(7'd30, 8'hFF, 8'hD7, 1);
        rd(pcmc_pkg::ADDR_OVF_FLAGS, 8'h08);
        rd(pcmc_pkg::ADDR_OVF_FLAGS, 8'h00);
        for (int s = 30; s < 33; s++) set_slot(7'(s), pcmc_pkg::DIR_TX, 8'h84);
        for (int s = 30; s < 33; s++) send(7'(s), 8'h00, 8'hFF, 1);
        hw.sync();
        send(7'd30, 8'hFF, 8'h57, 1);
        rd(pcmc_pkg::ADDR_OVF_FLAGS, 8'h10);
        $display("test overflow done");
    endtask

    // counter-driven boundary: samples at frame offsets 2, 4000, 4002 and 8001
    task automatic t_frame();
        hw.sync();
        send(7'd30, 8'hF0, 8'hFF, 1);
        repeat (FRAME_LEN - 4) @(posedge core_clk_i);
        send(7'd31, 8'hFF, 8'hFF, 1);
        send(7'd32, 8'hFF, 8'hF0, 1);
        repeat (FRAME_LEN - 3) @(posedge core_clk_i);
        send(7'd31, 8'hFF, 8'hFF, 1);
        $display("test frame done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_mix();
        t_level();
        t_member();
        t_law();
        t_ovf();
        t_frame();
        report_and_stop();
    end

    // about eight thousand cycles expected; cut off near sixteen thousand
    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
endmodule
